// File: core/sef_top.v
// serial eeprom front end: spi slave, array, id page, hold and standby
// Behaviour
// R1: 2048 byte array, serial access only
// R2: separate 32 byte identification page
// R3: locked identification page stays read only
// R4: selected only while chip select low
// R5: output bits change on falling clock edges
// R6: input sampled on rising clock edges
// R7: master sends commands and data on input
// R8: deselected means output floats
// R9: standby when deselected unless write running
// R10: need select falling edge after power up
// R11: hold pauses transfer, keeps shift state
// R12: hold floats output, ignores clock and data
// R13: master selects before asserting hold
// R14: bytes shifted most significant bit first
// R15: clock idle low or high both accepted
// R16: hold starts only while clock low
// R17: deselect in hold resets all but flags
// R18: after hold resume at same bit
// R19: deselect returns shift logic to idle
`timescale 1ns/1ps
`include "sef_map.vh"

module sef_top #(
    parameter WRITE_CYCLES = `SEF_T_WRITE_NS / `SEF_CLK_NS
) (
    input wire CLK,
    input wire RSTN,
    input wire CE,
    input wire SCK,
    input wire CS_N,
    input wire SI,
    input wire HOLD_N,
    output reg SO_O,
    output wire SO_OE,
    output wire STANDBY,
    output wire WRITE_IN_PROGRESS_FLAG,
    output wire WRITE_ENABLE_LATCH,
    output wire [7:0] RX_DATA,
    output wire RX_VALID,
    input wire RX_READY
);

    localparam [4:0] ST_CMD = 5'h01;
    localparam [4:0] ST_ADH = 5'h02;
    localparam [4:0] ST_ADL = 5'h04;
    localparam [4:0] ST_DATA = 5'h08;
    localparam [4:0] ST_IGN = 5'h10;
    localparam [3:0] SYNC_RST = `SEF_SYNC_RST;
    localparam [31:0] WR_ALL = WRITE_CYCLES - 1;
    localparam [22:0] WR_LAST = WR_ALL[22:0];

    function is_id;
        input [7:0] op;
        begin
            is_id = op[`SEF_ID_FLAG_BIT];
        end
    endfunction

    function is_rd;
        input [7:0] op;
        begin
            is_rd = (op == `SEF_OP_READ) || (op == `SEF_OP_RDID);
        end
    endfunction

    reg [7:0] array_mem [0:`SEF_ARRAY_DEPTH-1]; // R1
    reg [7:0] id_mem [0:`SEF_ID_DEPTH-1]; // R2

    // two-flop synchronisers for every pin input
    reg [3:0] s1_ff;
    reg [3:0] s2_ff;
    wire [3:0] pin_in = {HOLD_N, CS_N, SCK, SI};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
            always @(posedge CLK or negedge RSTN) begin
                if (!RSTN) begin
                    s1_ff[gi] <= SYNC_RST[gi];
                    s2_ff[gi] <= SYNC_RST[gi];
                end else if (CE) begin
                    s1_ff[gi] <= pin_in[gi];
                    s2_ff[gi] <= s1_ff[gi];
                end
            end
        end
    endgenerate

    wire si_s = s2_ff[`SEF_PIN_SI];
    wire sck_s = s2_ff[`SEF_PIN_SCK];
    wire cs_n_s = s2_ff[`SEF_PIN_CS];
    wire hold_n_s = s2_ff[`SEF_PIN_HOLD];

    reg sck_d_ff;
    reg armed_ff;
    reg hold_ff;
    reg [2:0] bit_ff;
    reg [7:0] sh_in_ff;
    reg [7:0] sh_out_ff;
    reg out_act_ff;
    reg [4:0] st_ff;
    reg [7:0] cmd_ff;
    reg [2:0] ah_ff;
    reg [10:0] addr_ff;
    reg wrote_ff;
    reg wel_ff;
    reg wip_ff;
    reg [22:0] wcnt_ff;
    reg locked_ff;
    reg [7:0] pend_ff;
    reg pend_v_ff;
    reg [7:0] fifo_mem [0:1];
    reg wp_ff;
    reg rp_ff;
    reg [1:0] cnt_ff;

    // a falling select edge is only honoured once select was seen high
    wire sel = armed_ff & ~cs_n_s; // R4 R10
    wire live = sel & ~hold_ff; // R12
    wire rise = live & sck_s & ~sck_d_ff; // R6 R15
    wire fall = live & ~sck_s & sck_d_ff; // R5 R15
    wire [7:0] byte_in = {sh_in_ff[6:0], si_s}; // R14
    wire byte_done = rise & (bit_ff == `SEF_BIT_LAST);
    wire [10:0] addr_new = {ah_ff, byte_in};
    wire lock_op = addr_ff[`SEF_LOCK_ADDR_BIT];
    wire fifo_full = cnt_ff[1];
    wire fifo_push = pend_v_ff & ~fifo_full;
    wire fifo_pop = RX_VALID & RX_READY;

    assign SO_OE = live & out_act_ff; // R8 R12
    assign STANDBY = ~sel & ~wip_ff; // R9
    assign WRITE_IN_PROGRESS_FLAG = wip_ff;
    assign WRITE_ENABLE_LATCH = wel_ff;
    assign RX_VALID = |cnt_ff;
    assign RX_DATA = fifo_mem[rp_ff];

    function [7:0] rd_byte;
        input [7:0] op;
        input [10:0] a;
        begin
            if (!is_id(op))
                rd_byte = array_mem[a];
            else if (a[`SEF_LOCK_ADDR_BIT])
                rd_byte = {7'h00, locked_ff};
            else
                rd_byte = id_mem[a[`SEF_ID_ADDR_W-1:0]];
        end
    endfunction

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            sck_d_ff <= 1'b0;
            armed_ff <= 1'b0;
            hold_ff <= 1'b0;
        end else if (CE) begin
            sck_d_ff <= sck_s;
            if (cs_n_s)
                armed_ff <= 1'b1; // R10
            if (!sel)
                hold_ff <= 1'b0; // R17
            else if (!hold_n_s && !sck_s)
                hold_ff <= 1'b1; // R11 R16
            else if (hold_n_s && !sck_s)
                hold_ff <= 1'b0; // R18
        end
    end

    // shift and command state; hold freezes it since rise and fall die
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            bit_ff <= `SEF_BIT_ZERO;
            sh_in_ff <= 8'h00;
            sh_out_ff <= 8'h00;
            out_act_ff <= 1'b0;
            st_ff <= ST_CMD;
            cmd_ff <= 8'h00;
            ah_ff <= 3'h0;
            addr_ff <= 11'h000;
            wrote_ff <= 1'b0;
            SO_O <= 1'b0;
        end else if (CE) begin
            if (!sel) begin
                bit_ff <= `SEF_BIT_ZERO; // R19 R17
                out_act_ff <= 1'b0;
                st_ff <= ST_CMD;
                wrote_ff <= 1'b0;
            end else begin
                if (fall && out_act_ff) begin
                    SO_O <= sh_out_ff[7]; // R5 R14
                    sh_out_ff <= {sh_out_ff[6:0], 1'b0};
                end
                if (rise) begin
                    sh_in_ff <= byte_in; // R6 R18
                    bit_ff <= bit_ff + 3'h1;
                end
                if (byte_done) begin
                    case (st_ff)
                        ST_CMD: begin
                            cmd_ff <= byte_in;
                            if (!wip_ff && (byte_in == `SEF_OP_READ ||
                                byte_in == `SEF_OP_WRITE ||
                                byte_in == `SEF_OP_RDID ||
                                byte_in == `SEF_OP_WRID))
                                st_ff <= ST_ADH;
                            else
                                st_ff <= ST_IGN;
                        end
                        ST_ADH: begin
                            ah_ff <= byte_in[2:0];
                            st_ff <= ST_ADL;
                        end
                        ST_ADL: begin
                            st_ff <= ST_DATA;
                            if (is_rd(cmd_ff)) begin
                                out_act_ff <= 1'b1;
                                sh_out_ff <= rd_byte(cmd_ff, addr_new);
                                addr_ff <= addr_new + 11'h001;
                            end else begin
                                addr_ff <= addr_new;
                            end
                        end
                        ST_DATA: begin
                            if (is_rd(cmd_ff)) begin
                                sh_out_ff <= rd_byte(cmd_ff, addr_ff);
                                addr_ff <= addr_ff + 11'h001;
                            end else begin
                                // writes wrap inside the 32 byte page
                                addr_ff <= (addr_ff & ~`SEF_PAGE_MASK) |
                                    ((addr_ff + 11'h001) & `SEF_PAGE_MASK);
                                wrote_ff <= wel_ff;
                            end
                        end
                        ST_IGN: st_ff <= ST_IGN;
                        default: st_ff <= ST_IGN;
                    endcase
                end
            end
        end
    end

    // memories have no reset; a byte lands as soon as it is complete
    always @(posedge CLK) begin
        if (CE && sel && byte_done && st_ff == ST_DATA && wel_ff &&
            cmd_ff == `SEF_OP_WRITE)
            array_mem[addr_ff] <= byte_in; // R1
        if (CE && sel && byte_done && st_ff == ST_DATA && wel_ff &&
            cmd_ff == `SEF_OP_WRID && !lock_op && !locked_ff)
            id_mem[addr_ff[`SEF_ID_ADDR_W-1:0]] <= byte_in; // R2 R3
        if (CE && fifo_push)
            fifo_mem[wp_ff] <= pend_ff;
    end

    // flags survive a deselect in hold; only a finished write clears wel and wip, and locked stays set
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            wel_ff <= 1'b0;
            wip_ff <= 1'b0;
            wcnt_ff <= 23'h000000;
            locked_ff <= 1'b0;
        end else if (CE) begin
            if (byte_done && st_ff == ST_CMD && !wip_ff &&
                byte_in == `SEF_OP_WREN)
                wel_ff <= 1'b1;
            if (byte_done && st_ff == ST_DATA && wel_ff &&
                cmd_ff == `SEF_OP_WRID && lock_op &&
                byte_in[`SEF_LOCK_DATA_BIT])
                locked_ff <= 1'b1; // R3
            if (!sel && wrote_ff && !hold_ff) begin
                wip_ff <= 1'b1; // R9
                wcnt_ff <= WR_LAST;
            end else if (wip_ff) begin
                if (wcnt_ff == 23'h000000) begin
                    wip_ff <= 1'b0;
                    wel_ff <= 1'b0;
                end else begin
                    wcnt_ff <= wcnt_ff - 23'h000001;
                end
            end
        end
    end

    // received bytes wait in a holding slot while the buffer is full
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pend_ff <= 8'h00;
            pend_v_ff <= 1'b0;
            wp_ff <= 1'b0;
            rp_ff <= 1'b0;
            cnt_ff <= 2'h0;
        end else if (CE) begin
            if (byte_done) begin
                pend_ff <= byte_in; // R7
                pend_v_ff <= 1'b1;
            end else if (fifo_push) begin
                pend_v_ff <= 1'b0;
            end
            if (fifo_push)
                wp_ff <= ~wp_ff;
            if (fifo_pop)
                rp_ff <= ~rp_ff;
            case ({fifo_push, fifo_pop})
                2'b10: cnt_ff <= cnt_ff + 2'h1;
                2'b01: cnt_ff <= cnt_ff - 2'h1;
                default: cnt_ff <= cnt_ff;
            endcase
        end
    end

endmodule // sef_top

// File: dv/sef_asserts.sv
// port checker for the serial eeprom front end
`timescale 1ns/1ps
module sef_asserts (
    input wire CLK,
    input wire RSTN,
    input wire SCK,
    input wire CS_N,
    input wire HOLD_N,
    input wire SO_O,
    input wire SO_OE,
    input wire STANDBY,
    input wire WRITE_IN_PROGRESS_FLAG,
    input wire WRITE_ENABLE_LATCH,
    input wire [7:0] RX_DATA,
    input wire RX_VALID,
    input wire RX_READY
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    chk_desel_float: assert property (CS_N [*4] |-> !SO_OE)
        else $error("output driven while deselected");
    chk_oe_selected: assert property ($rose(SO_OE) |-> !CS_N && HOLD_N)
        else $error("output enabled without select");
    chk_out_on_fall: assert property (
        $changed(SO_O) && SO_OE && $past(SO_OE) |-> !SCK && !$past(SCK, 2))
        else $error("output bit moved off a falling edge");
    chk_hold_float: assert property (
        (!HOLD_N && !SCK && !CS_N) [*5] |-> !SO_OE)
        else $error("output driven in hold");
    chk_busy_active: assert property (WRITE_IN_PROGRESS_FLAG |-> !STANDBY)
        else $error("standby during write cycle");
    chk_idle_standby: assert property ((CS_N && !WRITE_IN_PROGRESS_FLAG) [*6] |-> STANDBY)
        else $error("no standby while idle");
    chk_wel_kept: assert property (
        $fell(WRITE_ENABLE_LATCH) |-> $past(WRITE_IN_PROGRESS_FLAG) || $past(WRITE_IN_PROGRESS_FLAG, 2))
        else $error("write enable lost outside a write cycle");
    chk_rx_stall: assert property (
        RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA))
        else $error("buffered byte lost in stall");
    cover property ($rose(WRITE_IN_PROGRESS_FLAG));
    cover property ($rose(SO_OE));
    cover property ((RX_VALID && !RX_READY) [*4]);
endmodule // sef_asserts
bind sef_top sef_asserts u_chk (.CLK, .RSTN, .SCK, .CS_N, .HOLD_N, .SO_O,
    .SO_OE, .STANDBY, .WRITE_IN_PROGRESS_FLAG, .WRITE_ENABLE_LATCH, .RX_DATA, .RX_VALID, .RX_READY);

// File: dv/sef_master.sv
// spi master model on the far side of the front end
`timescale 1ns/1ps
module sef_master (
    output logic sck,
    output logic cs_n,
    output logic si,
    output logic hold_n,
    input wire so_o,
    input wire so_oe
);
    logic cpol = 1'b0;
    logic live = 1'b0;
    logic q_last = 1'b0;
    logic [7:0] rx = 8'h00;
    logic [7:0] sent[$];
    // no pull on the data line, so a floating line reads inverted
    wire q = so_oe ? so_o : ~q_last;
    initial begin
        sck = 1'b0;
        cs_n = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
    end
    always @(so_o or so_oe) if (so_oe === 1'b1) q_last = so_o;
    task automatic sel(input logic s);
        #80 sck = cpol;
        #80 cs_n = s;
        #80;
    endtask
    task automatic pause(input int n, input logic drop);
        sck = 1'b0;
        #80 hold_n = 1'b0;
        repeat (n) begin
            #80 sck = ~sck;
            si = ~si;
        end
        if (drop) #80 cs_n = 1'b1;
        #80 hold_n = 1'b1;
        #80;
    endtask
    task automatic xb(input logic [7:0] d, input int hb);
        for (int i = 7; i >= 0; i--) begin
            if (i == hb) pause(6, 1'b0);
            sck = 1'b0;
            si = d[i];
            #80 sck = 1'b1;
            rx[i] = q;
            if (i == 0 && live) sent.push_back(d);
            #80;
        end
    endtask
endmodule // sef_master

// File: dv/serial_eeprom_spi_front_end_test.sv
// self-checking bench for the serial eeprom front end
`timescale 1ns/1ps
module serial_eeprom_spi_front_end_test;
    logic CLK = 1'b0;
    logic RSTN = 1'b0;
    logic RX_READY = 1'b0;
    logic CE = 1'b1;
    logic stall = 1'b0;
    wire SO_O, SO_OE, STANDBY, WRITE_IN_PROGRESS_FLAG, WRITE_ENABLE_LATCH, RX_VALID, SCK, CS_N, SI, HOLD_N;
    wire [7:0] RX_DATA;
    int errors = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [7:0] d;
    logic [10:0] a;
    sef_top #(.WRITE_CYCLES(20)) u_dut (.CLK(CLK), .RSTN(RSTN), .CE(CE),
        .SCK(SCK), .CS_N(CS_N), .SI(SI), .HOLD_N(HOLD_N), .SO_O(SO_O),
        .SO_OE(SO_OE), .STANDBY(STANDBY), .WRITE_IN_PROGRESS_FLAG(WRITE_IN_PROGRESS_FLAG), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH),
        .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_READY(RX_READY));
    sef_master m (.sck(SCK), .cs_n(CS_N), .si(SI), .hold_n(HOLD_N),
        .so_o(SO_O), .so_oe(SO_OE));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op);
        m.sel(1'b0);
        m.xb(op, 9);
        m.sel(1'b1);
    endtask
    task automatic frame(input logic [7:0] op, input logic [10:0] ad,
            input int n, input int hb, input logic [7:0] b);
        m.sel(1'b0);
        m.xb(op, 9);
        m.xb({5'h00, ad[10:8]}, 9);
        m.xb(ad[7:0], 9);
        for (int k = 0; k < n; k++) begin
            m.xb(b + k[7:0], k == 0 ? hb : 9);
            if (op[0]) chk(m.rx, b + k[7:0]);
        end
        m.sel(1'b1);
        chk({7'h00, SO_OE}, 8'h00);
    endtask
    task automatic settle;
        chk({6'h00, WRITE_IN_PROGRESS_FLAG, STANDBY}, 8'h02);
        // a frozen clock enable must stretch the write cycle
        CE = 1'b0;
        repeat (30) @(posedge CLK);
        #1 chk({6'h00, WRITE_IN_PROGRESS_FLAG, STANDBY}, 8'h02);
        CE = 1'b1;
        for (int i = 0; i < 60 && WRITE_IN_PROGRESS_FLAG !== 1'b0; i++) @(posedge CLK);
        #1 chk({5'h00, WRITE_ENABLE_LATCH, WRITE_IN_PROGRESS_FLAG, STANDBY}, 8'h01);
    endtask
    initial forever #5 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        RX_READY <= #1 !stall && ($urandom_range(1) == 1);
        if (CE === 1'b1 && RX_VALID === 1'b1 && RX_READY === 1'b1)
            chk(RX_DATA, m.sent.pop_front());
        if (cyc == 40000) begin
            errors++;
            end_of_test;
        end
    end
    initial begin
        d = $urandom(32'h53c4);
        repeat (10) @(posedge CLK);
        #1 RSTN = 1'b1;
        m.xb(8'h06, 9);
        m.sel(1'b1);
        chk({7'h00, WRITE_ENABLE_LATCH}, 8'h00);
        $display("unarmed test done");
        m.live = 1'b1;
        for (int md = 0; md < 2; md++) begin
            m.cpol = md[0];
            a = 11'($urandom);
            a[4] = 1'b0;
            d = 8'($urandom);
            cmd(8'h06);
            chk({7'h00, WRITE_ENABLE_LATCH}, 8'h01);
            frame(8'h02, a, 4, $urandom_range(7), d);
            settle;
            frame(8'h03, a, 4, $urandom_range(7), d);
            $display("mode %0d test done", md);
        end
        cmd(8'h06);
        stall = 1'b1;
        m.sel(1'b0);
        m.xb(8'h02, 9);
        m.xb({5'h00, a[10:8]}, 9);
        m.xb(a[7:0], 9);
        m.pause(2, 1'b1);
        chk({5'h00, RX_VALID, WRITE_ENABLE_LATCH, WRITE_IN_PROGRESS_FLAG}, 8'h06);
        stall = 1'b0;
        frame(8'h03, a, 2, 9, d);
        $display("abandon test done");
        frame(8'h82, 11'h000, 1, 9, d);
        settle;
        cmd(8'h06);
        frame(8'h82, 11'h400, 1, 9, 8'h02);
        settle;
        frame(8'h83, 11'h400, 1, 9, 8'h01);
        cmd(8'h06);
        frame(8'h82, 11'h000, 1, 9, ~d);
        frame(8'h83, 11'h000, 1, 9, d);
        $display("id page test done");
        repeat (50) @(posedge CLK);
        chk(8'(m.sent.size()), 8'h00);
        end_of_test;
    end
endmodule // serial_eeprom_spi_front_end_test

// File: inc/sef_map.vh
// constants for the serial eeprom front end
`ifndef SEF_MAP_VH
`define SEF_MAP_VH

`define SEF_ARRAY_DEPTH 2048
`define SEF_ID_DEPTH 32
`define SEF_ADDR_W 11
`define SEF_ID_ADDR_W 5
`define SEF_BIT_LAST 3'h7
`define SEF_BIT_ZERO 3'h0
`define SEF_PAGE_MASK 11'h01f

`define SEF_OP_WREN 8'h06
`define SEF_OP_READ 8'h03
`define SEF_OP_WRITE 8'h02
`define SEF_OP_RDID 8'h83
`define SEF_OP_WRID 8'h82
`define SEF_ID_FLAG_BIT 7
`define SEF_LOCK_ADDR_BIT 10
`define SEF_LOCK_DATA_BIT 1

// select sync resets low so that reset alone never arms the device
`define SEF_SYNC_RST 4'h8
`define SEF_PIN_SI 0
`define SEF_PIN_SCK 1
`define SEF_PIN_CS 2
`define SEF_PIN_HOLD 3

`define SEF_CLK_NS 10
`define SEF_T_WRITE_NS 5000000

`endif
